// ### hdl/pcs_pkg.sv
// Package with the register map and field layout of the clock status block.
package pcs_pkg;
  // Register byte addresses on the system bus.
  localparam logic [31:0] ADDR_PLL_A_CFG = 32'hfffffc28;
  localparam logic [31:0] ADDR_PCK0 = 32'hfffffc40;
  localparam logic [31:0] ADDR_PCK1 = 32'hfffffc44;
  localparam logic [31:0] ADDR_IRQ_EN = 32'hfffffc60;
  localparam logic [31:0] ADDR_IRQ_DIS = 32'hfffffc64;
  localparam logic [31:0] ADDR_STATUS = 32'hfffffc68;
  localparam logic [31:0] ADDR_MASK = 32'hfffffc6c;
  localparam logic [31:0] ADDR_EVENT = 32'hfffffc70;
  localparam logic [31:0] ADDR_PUMP = 32'hfffffc80;
  // Shared bit map of enable, disable, status, mask and event registers.
  localparam int BIT_OSC = 0;
  localparam int BIT_LOCK_A = 1;
  localparam int BIT_LOCK_B = 2;
  localparam int BIT_MCK = 3;
  localparam int BIT_SLOW_SRC = 7;
  localparam int BIT_PCK0 = 8;
  localparam int BIT_PCK1 = 9;
  // Bits that are interrupt sources.
  localparam logic [31:0] IRQ_BITS = 32'h0000030f;
  // Programmable clock fields: source at 1:0, prescaler at 4:2.
  localparam int PCK_SRC_LSB = 0;
  localparam int PCK_PRESCALE_LSB = 2;
  localparam logic [31:0] PCK_BITS = 32'h0000001f;
  localparam logic [2:0] PRESCALE_RESERVED = 3'h7;
  // Source select codes.
  localparam logic [1:0] SRC_SLOW = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_PLL_A = 2'h2;
  localparam logic [1:0] SRC_PLL_B = 2'h3;
  // Lock delay field of the PLL A configuration, bits 13:8.
  localparam int LOCK_DELAY_LSB = 8;
  localparam logic [31:0] LOCK_DELAY_BITS = 32'h00003f00;
  // Charge pump current bits.
  localparam logic [31:0] PUMP_BITS = 32'h00010001;
  // Reset values.
  localparam logic [31:0] PCK_RESET = 32'h00000000;
  localparam logic [31:0] PUMP_RESET = 32'h00000000;
  localparam logic [31:0] IRQ_EN_RESET = 32'h00000000;
  localparam logic [5:0] LOCK_DELAY_RESET = 6'h00;
  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pcs_pkg

// ### hdl/pcs_top.sv
// Clock status, interrupt and programmable clock configuration block.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pcs_top (
  input wire logic aclk, // System clock, 10 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response code.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response code.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic osc_stable, // Main oscillator stable, from a pin.
  input wire logic pll_b_locked, // PLL B lock indication, from a pin.
  input wire logic master_clk_ready, // Master clock ready, from a pin.
  input wire logic slow_clk_source, // One when the crystal drives slow clock.
  input wire logic slow_clk, // Slow clock, sampled as a plain input.
  output logic pll_a_locked, // PLL A lock state.
  output logic [1:0] pck0_source_select, // Clock 0 source select.
  output logic [2:0] pck0_prescale_code, // Clock 0 prescaler code.
  output logic [1:0] pck1_source_select, // Clock 1 source select.
  output logic [2:0] pck1_prescale_code, // Clock 1 prescaler code.
  output logic pump_current_a, // PLL A charge pump current bit.
  output logic pump_current_b, // PLL B charge pump current bit.
  output logic irq // Level interrupt request, active high.
);

  // Merge a write into a stored word under the byte strobes.
  function automatic logic [31:0] strobe_merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : strobe_merge

  // Readiness of a programmable clock's chosen source.
  function automatic logic src_ready(input logic [1:0] sel,
      input logic [31:0] st);
    case (sel)
      pcs_pkg::SRC_SLOW: src_ready = 1'b1;
      pcs_pkg::SRC_MAIN: src_ready = st[pcs_pkg::BIT_OSC];
      pcs_pkg::SRC_PLL_A: src_ready = st[pcs_pkg::BIT_LOCK_A];
      default: src_ready = st[pcs_pkg::BIT_LOCK_B];
    endcase
  endfunction : src_ready

  // Two-stage synchronisers for all pin inputs; stage one feeds stage two.
  logic [4:0] pin_meta; // First synchroniser stage.
  logic [4:0] pin_sync; // Second synchroniser stage, safe to read.
  logic slow_prev; // Previous synchronised slow clock level.
  wire logic [4:0] pin_raw = {slow_clk, slow_clk_source, master_clk_ready,
                              pll_b_locked, osc_stable};
  wire logic slow_tick = pin_sync[4] & ~slow_prev; // Slow clock rising edge.

  // Pins are asynchronous to aclk, so they pass two flops first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      slow_prev <= 1'b0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      slow_prev <= pin_sync[4];
    end
  end

  // Write channel holding registers; address and data are taken apart.
  logic aw_held; // Write address captured.
  logic w_held; // Write data captured.
  logic [31:0] aw_addr; // Captured write address.
  logic [31:0] w_data; // Captured write data.
  logic [3:0] w_strb; // Captured write strobes.
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take = s_axi_wvalid & s_axi_wready;
  wire logic wr_go = aw_held & w_held & ~s_axi_bvalid; // Perform the write.

  // Write decode, valid only in the cycle of wr_go.
  wire logic wr_pll_a = wr_go & (aw_addr == pcs_pkg::ADDR_PLL_A_CFG);
  wire logic wr_pck0 = wr_go & (aw_addr == pcs_pkg::ADDR_PCK0);
  wire logic wr_pck1 = wr_go & (aw_addr == pcs_pkg::ADDR_PCK1);
  wire logic wr_en = wr_go & (aw_addr == pcs_pkg::ADDR_IRQ_EN);
  wire logic wr_dis = wr_go & (aw_addr == pcs_pkg::ADDR_IRQ_DIS);
  wire logic wr_evt = wr_go & (aw_addr == pcs_pkg::ADDR_EVENT);
  wire logic wr_pump = wr_go & (aw_addr == pcs_pkg::ADDR_PUMP);
  wire logic wr_ro = wr_go & ((aw_addr == pcs_pkg::ADDR_STATUS) |
                              (aw_addr == pcs_pkg::ADDR_MASK));
  wire logic wr_hit = wr_pll_a | wr_pck0 | wr_pck1 | wr_en | wr_dis |
                      wr_evt | wr_pump | wr_ro;
  wire logic [31:0] wr_word = strobe_merge(32'h00000000, w_data, w_strb);

  // Write channel: each side is accepted once and held until the response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pcs_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        // Unmapped addresses answer with a slave error.
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready is registered so the outputs come straight from flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held & ~aw_take & ~wr_go;
      s_axi_wready <= ~w_held & ~w_take & ~wr_go;
    end
  end

  // Configuration registers.
  logic [31:0] pck_cfg [2]; // Programmable clock configurations.
  logic [31:0] pump_cfg; // Charge pump current register.
  logic [31:0] irq_en; // Interrupt source enables, one per source.
  logic [5:0] lock_delay; // PLL A lock delay in slow clock cycles.
  logic [5:0] lock_cnt; // Slow clock cycles still to wait.
  logic lock_wait; // PLL A lock countdown running.
  logic [1:0] pck_ready; // Programmable clock ready flags.
  logic [31:0] status_prev; // Status of the previous cycle.
  logic [31:0] evt; // Sticky interrupt event flags.

  wire logic [31:0] pll_a_word = strobe_merge({18'h00000, lock_delay, 8'h00},
                                              w_data, w_strb);

  // Programmable clocks; only source and prescaler bits are kept.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pck_cfg[0] <= pcs_pkg::PCK_RESET;
      pck_cfg[1] <= pcs_pkg::PCK_RESET;
    end else begin
      if (wr_pck0) begin
        pck_cfg[0] <= strobe_merge(pck_cfg[0], w_data, w_strb) &
                      pcs_pkg::PCK_BITS;
      end
      if (wr_pck1) begin
        pck_cfg[1] <= strobe_merge(pck_cfg[1], w_data, w_strb) &
                      pcs_pkg::PCK_BITS;
      end
    end
  end

  // Charge pump bits are stored as written; software sets both to one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pump_cfg <= pcs_pkg::PUMP_RESET;
    end else if (wr_pump) begin
      pump_cfg <= strobe_merge(pump_cfg, w_data, w_strb) & pcs_pkg::PUMP_BITS;
    end
  end

  // Enable and disable commands; a disable in the same write wins nothing,
  // as each command is its own register and writes never overlap.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en <= pcs_pkg::IRQ_EN_RESET;
    end else if (wr_en) begin
      irq_en <= irq_en | (wr_word & pcs_pkg::IRQ_BITS);
    end else if (wr_dis) begin
      irq_en <= irq_en & ~(wr_word & pcs_pkg::IRQ_BITS);
    end
  end

  // PLL A lock: a configuration write drops lock and counts slow clocks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_delay <= pcs_pkg::LOCK_DELAY_RESET;
      lock_cnt <= 6'h00;
      lock_wait <= 1'b0;
      pll_a_locked <= 1'b0;
    end else if (wr_pll_a) begin
      lock_delay <= pll_a_word[pcs_pkg::LOCK_DELAY_LSB +: 6];
      lock_cnt <= pll_a_word[pcs_pkg::LOCK_DELAY_LSB +: 6];
      lock_wait <= 1'b1;
      pll_a_locked <= 1'b0;
    end else if (lock_wait && lock_cnt == 6'h00) begin
      lock_wait <= 1'b0;
      pll_a_locked <= 1'b1;
    end else if (lock_wait && slow_tick) begin
      lock_cnt <= lock_cnt - 6'h01;
    end
  end

  // Level status, assembled from synchronised pins and internal state.
  wire logic [31:0] status = {22'h000000, pck_ready, pin_sync[3], 3'h0,
                              pin_sync[2], pin_sync[1], pll_a_locked,
                              pin_sync[0]};

  // A clock is ready when its source is; a write restarts the check,
  // so it reads not ready for at least one cycle after reprogramming.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pck_ready <= 2'h0;
    end else begin
      pck_ready[0] <= ~wr_pck0 &
          src_ready(pck_cfg[0][pcs_pkg::PCK_SRC_LSB +: 2], status);
      pck_ready[1] <= ~wr_pck1 &
          src_ready(pck_cfg[1][pcs_pkg::PCK_SRC_LSB +: 2], status);
    end
  end

  // Sticky events on rising status; a new event beats a same-cycle clear.
  wire logic [31:0] evt_rise = status & ~status_prev & pcs_pkg::IRQ_BITS;
  wire logic [31:0] evt_clr = wr_evt ? wr_word : 32'h00000000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_prev <= 32'h00000000;
      evt <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      status_prev <= status;
      evt <= (evt & ~evt_clr) | evt_rise;
      irq <= |(evt & irq_en);
    end
  end

  // Drive the configuration outputs from their registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pck0_source_select <= 2'h0;
      pck0_prescale_code <= 3'h0;
      pck1_source_select <= 2'h0;
      pck1_prescale_code <= 3'h0;
      pump_current_a <= 1'b0;
      pump_current_b <= 1'b0;
    end else begin
      pck0_source_select <= pck_cfg[0][pcs_pkg::PCK_SRC_LSB +: 2];
      pck0_prescale_code <= pck_cfg[0][pcs_pkg::PCK_PRESCALE_LSB +: 3];
      pck1_source_select <= pck_cfg[1][pcs_pkg::PCK_SRC_LSB +: 2];
      pck1_prescale_code <= pck_cfg[1][pcs_pkg::PCK_PRESCALE_LSB +: 3];
      pump_current_a <= pump_cfg[0];
      pump_current_b <= pump_cfg[16];
    end
  end

  // Read decode; write-only commands read as zero.
  wire logic [31:0] ar = s_axi_araddr;
  wire logic rd_hit = (ar == pcs_pkg::ADDR_PLL_A_CFG) |
                      (ar == pcs_pkg::ADDR_PCK0) | (ar == pcs_pkg::ADDR_PCK1) |
                      (ar == pcs_pkg::ADDR_IRQ_EN) |
                      (ar == pcs_pkg::ADDR_IRQ_DIS) |
                      (ar == pcs_pkg::ADDR_STATUS) |
                      (ar == pcs_pkg::ADDR_MASK) |
                      (ar == pcs_pkg::ADDR_EVENT) | (ar == pcs_pkg::ADDR_PUMP);
  wire logic [31:0] mask_word = ~irq_en & pcs_pkg::IRQ_BITS;
  wire logic [31:0] rd_word =
      (ar == pcs_pkg::ADDR_PLL_A_CFG) ? {18'h00000, lock_delay, 8'h00} :
      (ar == pcs_pkg::ADDR_PCK0) ? pck_cfg[0] :
      (ar == pcs_pkg::ADDR_PCK1) ? pck_cfg[1] :
      (ar == pcs_pkg::ADDR_STATUS) ? status :
      (ar == pcs_pkg::ADDR_MASK) ? mask_word :
      (ar == pcs_pkg::ADDR_EVENT) ? evt :
      (ar == pcs_pkg::ADDR_PUMP) ? pump_cfg : 32'h00000000;

  // Read channel: one read at a time, data one cycle after the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= pcs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid;
    end
  end

  // Checks on the block's own behaviour.
  a_src_out: assert property (@(posedge aclk)
      disable iff (!aresetn) wr_pck0 && w_strb[0] |->
      ##2 pck0_source_select == $past(wr_word[1:0], 2))
    else $error("Clock 0 source output does not follow the write.");
  a_prescale_code_out: assert property (@(posedge aclk)
      disable iff (!aresetn) wr_pck1 && w_strb[0] |->
      ##2 pck1_prescale_code == $past(w_data[4:2], 2))
    else $error("Clock 1 prescaler output does not follow the write.");
  a_en_sets: assert property (@(posedge aclk)
      disable iff (!aresetn)
      wr_en |=> (irq_en & ($past(wr_word) & pcs_pkg::IRQ_BITS)) ==
               ($past(wr_word) & pcs_pkg::IRQ_BITS))
    else $error("Enable command did not enable its sources.");
  a_dis_clears: assert property (@(posedge aclk)
      disable iff (!aresetn)
      wr_dis |=> (irq_en & $past(wr_word)) == 32'h00000000)
    else $error("Disable command did not disable its sources.");
  a_en_keeps: assert property (@(posedge aclk)
      disable iff (!aresetn)
      wr_en |=> (irq_en & ~$past(wr_word)) == ($past(irq_en) &
                ~$past(wr_word)))
    else $error("Enable command changed a source written as zero.");
  a_mask_polarity: assert property (@(posedge aclk)
      disable iff (!aresetn)
      wr_dis |=> (mask_word & $past(wr_word) & pcs_pkg::IRQ_BITS) ==
                 ($past(wr_word) & pcs_pkg::IRQ_BITS))
    else $error("Mask register does not read one for a disabled source.");
  a_lock_drop: assert property (@(posedge aclk)
      disable iff (!aresetn) wr_pll_a |=> !pll_a_locked)
    else $error("PLL A lock did not drop on a configuration write.");
  a_lock_wait: assert property (@(posedge aclk)
      disable iff (!aresetn)
      lock_wait && lock_cnt != 6'h00 |=> !pll_a_locked)
    else $error("PLL A locked before its slow clock count ran out.");
  a_lock_end: assert property (@(posedge aclk)
      disable iff (!aresetn)
      lock_wait && lock_cnt == 6'h00 && !wr_pll_a |=> pll_a_locked)
    else $error("PLL A did not lock when its count ran out.");
  a_irq_level: assert property (@(posedge aclk)
      disable iff (!aresetn)
      |(evt & irq_en) |=> irq)
    else $error("Interrupt not raised for an enabled event.");
  a_irq_quiet: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (evt & irq_en) == 32'h00000000 |=> !irq)
    else $error("Interrupt raised with no enabled event.");
  // Pins reach status two edges after they are sampled, once out of reset.
  a_status_pins: assert property (@(posedge aclk)
      disable iff (!aresetn) $past(aresetn, 2) |->
      status[pcs_pkg::BIT_OSC] == $past(osc_stable, 2) &&
      status[pcs_pkg::BIT_SLOW_SRC] == $past(slow_clk_source, 2))
    else $error("Status does not show the synchronised pins.");
  a_pck_ready: assert property (@(posedge aclk)
      disable iff (!aresetn) wr_pck0 |=> !pck_ready[0])
    else $error("Clock 0 stayed ready across reprogramming.");

endmodule : pcs_top
`default_nettype wire

// ### verification/tb_pcs_top.sv
// Self-checking bench for the clock status and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module tb_pcs_top;
  // One register access: address, data, write flag, read value, response.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic [31:0] exp;
    logic [1:0] resp;
  } pcs_row_t;
  // Ordinary accesses; the status row comes first, before any clock write.
  localparam pcs_row_t ROWS [7] = '{
    '{pcs_pkg::ADDR_STATUS, 32'hffffffff, 1'h1, 32'h00000300,
      pcs_pkg::RESP_OKAY},
    '{pcs_pkg::ADDR_MASK, 32'hffffffff, 1'h1, 32'h0000030f,
      pcs_pkg::RESP_OKAY},
    '{pcs_pkg::ADDR_PCK0, 32'hffffffff, 1'h1, 32'h0000001f,
      pcs_pkg::RESP_OKAY},
    '{pcs_pkg::ADDR_PCK1, 32'h00000009, 1'h1, 32'h00000009,
      pcs_pkg::RESP_OKAY},
    '{pcs_pkg::ADDR_PUMP, 32'hffffffff, 1'h1, 32'h00010001,
      pcs_pkg::RESP_OKAY},
    '{pcs_pkg::ADDR_IRQ_EN, 32'h00000000, 1'h1, 32'h00000000,
      pcs_pkg::RESP_OKAY},
    '{32'hfffffc90, 32'h12345678, 1'h1, 32'h00000000, pcs_pkg::RESP_SLVERR}
  };
  localparam int LIMIT = 5000; // Cycle ceiling; the run needs under 2000.
  localparam int LOCK_N [2] = '{0, 5}; // Lock delays tried, in slow edges.
  // Design inputs, all given a value at time zero.
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  // Ready lines stay high, which the bus allows for a master.
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [3:0] s_axi_wstrb = 4'hf; // Whole words only.
  logic osc_stable = 1'h0, pll_b_locked = 1'h0, master_clk_ready = 1'h0;
  logic slow_clk_source = 1'h0, slow_clk = 1'h0;
  // Design outputs.
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pll_a_locked, pump_current_a, pump_current_b, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, pck0_source_select;
  logic [1:0] pck1_source_select;
  logic [2:0] pck0_prescale_code, pck1_prescale_code;
  logic [31:0] s_axi_rdata;
  // Bench bookkeeping.
  int miscompares = 0, checked = 0, cycles = 0, slow_edges = 0;
  int n, waits, e0;
  logic [1:0] slow_div = 2'h0, r;
  logic [31:0] d;

  pcs_top i_pcs_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .osc_stable, .pll_b_locked, .master_clk_ready, .slow_clk_source,
    .slow_clk, .pll_a_locked, .pck0_source_select, .pck0_prescale_code,
    .pck1_source_select, .pck1_prescale_code, .pump_current_a,
    .pump_current_b, .irq);

  // The 100 ns system clock.
  initial begin
    forever #50 aclk = ~aclk;
  end

  // Slow clock of eight system cycles; rising edges are counted here.
  always @(posedge aclk) begin
    slow_div <= slow_div + 2'h1;
    if (slow_div == 2'h3) begin
      slow_clk <= ~slow_clk;
      if (!slow_clk) slow_edges <= slow_edges + 1;
    end
  end

  // A hang ends the run as a failure.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end

  // Prints the verdict and stops.
  task automatic complete_run();
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic idle(input int k);
    repeat (k) @(posedge aclk);
  endtask : idle

  // Bus write; entered just after an edge, each channel held until taken.
  task automatic axi_write(input logic [31:0] a, input logic [31:0] v,
                           output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    forever begin
      @(posedge aclk);
      if (aw_done && w_done && s_axi_bvalid === 1'h1) begin
        resp = s_axi_bresp;
        break;
      end
      if (s_axi_awvalid && s_axi_awready === 1'h1) begin
        aw_done = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'h1) begin
        w_done = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
  endtask : axi_write

  // Bus read; the address is held until taken, then data is awaited.
  task automatic axi_read(input logic [31:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
    logic ar_done;
    ar_done = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    forever begin
      @(posedge aclk);
      if (ar_done && s_axi_rvalid === 1'h1) begin
        v = s_axi_rdata;
        resp = s_axi_rresp;
        break;
      end
      if (s_axi_arvalid && s_axi_arready === 1'h1) begin
        ar_done = 1'h1;
        s_axi_arvalid <= 1'h0;
      end
    end
  endtask : axi_read

  // Write expecting an OKAY answer.
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [1:0] resp;
    axi_write(a, v, resp);
    check({30'h0, resp}, {30'h0, pcs_pkg::RESP_OKAY});
  endtask : wr

  // Read expecting an OKAY answer carrying the given word.
  task automatic expect_reg(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] got;
    logic [1:0] resp;
    axi_read(a, got, resp);
    check({30'h0, resp}, {30'h0, pcs_pkg::RESP_OKAY});
    check(got, v);
  endtask : expect_reg

  initial begin
    // The listed outputs all read zero while reset is held.
    idle(20);
    check(32'({pll_a_locked, pck0_source_select, pck0_prescale_code, irq,
      pck1_source_select, pck1_prescale_code, pump_current_a, s_axi_bvalid,
      pump_current_b, s_axi_rvalid, s_axi_awready}), 32'h0);
    aresetn <= 1'h1;
    idle(2);
    // Table of ordinary accesses, read back after each write.
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) axi_write(ROWS[i].addr, ROWS[i].wdata, r);
      if (ROWS[i].wr) check({30'h0, r}, {30'h0, ROWS[i].resp});
      axi_read(ROWS[i].addr, d, r);
      check({30'h0, r}, {30'h0, ROWS[i].resp});
      if (ROWS[i].resp == pcs_pkg::RESP_OKAY) check(d, ROWS[i].exp);
    end
    check({30'h0, pump_current_b, pump_current_a}, 32'h3);
    // Every source code beside every prescaler code, reserved one too.
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 8; p++) begin
        wr(pcs_pkg::ADDR_PCK0, 32'((p << 2) | s));
        idle(1);
        check({27'h0, pck0_prescale_code, pck0_source_select},
          32'((p << 2) | s));
      end
    end
    // Status follows the pins; clock 1 on main follows the oscillator.
    wr(pcs_pkg::ADDR_PCK0, 32'h0);
    wr(pcs_pkg::ADDR_PCK1, 32'h1);
    osc_stable <= 1'h1;
    pll_b_locked <= 1'h1;
    master_clk_ready <= 1'h1;
    slow_clk_source <= 1'h1;
    idle(6);
    expect_reg(pcs_pkg::ADDR_STATUS, 32'h0000038d);
    osc_stable <= 1'h0;
    idle(6);
    expect_reg(pcs_pkg::ADDR_STATUS, 32'h0000018c);
    osc_stable <= 1'h1;
    idle(6);
    check({31'h0, irq}, 32'h0);
    // Enable, disable and zero writes against the mask and the interrupt.
    wr(pcs_pkg::ADDR_EVENT, 32'hffffffff);
    wr(pcs_pkg::ADDR_IRQ_EN, 32'h1);
    expect_reg(pcs_pkg::ADDR_MASK, 32'h0000030e);
    osc_stable <= 1'h0;
    idle(6);
    osc_stable <= 1'h1;
    idle(6);
    check({31'h0, irq}, 32'h1);
    wr(pcs_pkg::ADDR_IRQ_DIS, 32'h1);
    idle(3);
    check({31'h0, irq}, 32'h0);
    wr(pcs_pkg::ADDR_IRQ_EN, 32'h0);
    expect_reg(pcs_pkg::ADDR_MASK, 32'h0000030f);
    wr(pcs_pkg::ADDR_IRQ_EN, 32'h30f);
    idle(3);
    check({31'h0, irq}, 32'h1);
    wr(pcs_pkg::ADDR_IRQ_DIS, 32'h300);
    wr(pcs_pkg::ADDR_IRQ_DIS, 32'h0);
    expect_reg(pcs_pkg::ADDR_MASK, 32'h00000300);
    wr(pcs_pkg::ADDR_EVENT, 32'h1);
    idle(3);
    check({31'h0, irq}, 32'h0);
    // Lock of PLL A waits the programmed count of slow edges.
    foreach (LOCK_N[k]) begin
      wr(pcs_pkg::ADDR_PLL_A_CFG, 32'(LOCK_N[k]) << pcs_pkg::LOCK_DELAY_LSB);
      e0 = slow_edges;
      if (k > 0) check({31'h0, pll_a_locked}, 32'h0);
      waits = 0;
      while (pll_a_locked !== 1'h1 && waits < 300) begin
        @(posedge aclk);
        waits++;
      end
      n = slow_edges - e0;
      check(32'(n + 1 >= LOCK_N[k] && n <= LOCK_N[k] + 1), 32'h1);
      axi_read(pcs_pkg::ADDR_STATUS, d, r);
      check({31'h0, d[pcs_pkg::BIT_LOCK_A]}, 32'h1);
    end
    idle(4);
    check({31'h0, irq}, 32'h1);
    check({27'h0, pck1_prescale_code, pck1_source_select}, 32'h1);
    // A second reset in mid-run restores the reset state.
    aresetn <= 1'h0;
    idle(2);
    aresetn <= 1'h1;
    idle(2);
    check({24'h0, irq, pump_current_b, pump_current_a, pck1_prescale_code,
      pck1_source_select}, 32'h0);
    expect_reg(pcs_pkg::ADDR_MASK, 32'h0000030f);
    complete_run();
  end
endmodule : tb_pcs_top
`default_nettype wire
